// *** hw/flash_cmd_pkg.sv ***
// Constants and types for the flash command interpreter and status byte
// How it works
// - Byte b7 enters wide address mode, no address, single-wire only.
// - Byte b9 enters deep sleep, no address, both instruction modes.
// - Byte b0 is an alternate suspend command, no address, both modes.
// - Byte c7 is an alternate whole-array erase, no address, both modes.
// - Lock bit clear means no write protection; it defaults to zero.
// - Stored protect range bits 4..2 apply while config bit 3 is zero.
// - Volatile protection forces stored range to 111b and freezes it.
// - Stored bit 6 is read-only, zero, seeds the program error flag.
// - Stored bit 5 is read-only, zero, seeds the erase error flag.
// - Stored bit 1 is read-only, zero, seeds the write enable latch.
// - Stored bit 0 is read-only, zero, seeds the busy flag.
// - Latch clear ignores writes, program, erase; only enable/disable move it.
// - Volatile range mirrors stored range unless protection is volatile.
package flash_cmd_pkg;
	localparam logic [7:0] OP_WIDE_ADDR   = 8'hb7;
	localparam logic [7:0] OP_SLEEP       = 8'hb9;
	localparam logic [7:0] OP_SUSPEND_ALT = 8'hb0;
	localparam logic [7:0] OP_ERASE_ALT   = 8'hc7;
	localparam logic [7:0] OP_LEGACY_RST  = 8'hf0;
	localparam logic [7:0] OP_WREN        = 8'h06;
	localparam logic [7:0] OP_WRDI        = 8'h04;
	localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
	localparam logic [7:0] STAT_NV_RESET  = 8'h00;
	localparam logic [2:0] RANGE_FROZEN   = 3'h7;
	localparam int unsigned BIT_LOCK      = 7;
	localparam int unsigned BIT_RANGE_LO  = 2;
	localparam int unsigned BIT_WEL       = 1;
	localparam logic [7:0] STAT_RO_MASK   = 8'h63;
	localparam int unsigned CFG_VOL_BIT   = 3;
	localparam logic [2:0] BIT_CNT_LAST   = 3'h7;
	localparam logic [2:0] NIB_CNT_LAST   = 3'h1;

	typedef enum logic [1:0] {
		ST_OPCODE = 2'b00,
		ST_DATA   = 2'b01,
		ST_IGNORE = 2'b11
	} phase_e;

	typedef struct packed {
		logic wide_addr;
		logic sleep;
		logic suspend;
		logic erase;
		logic soft_reset;
	} cmd_pulse_s;

	typedef struct packed {
		phase_e     phase;
		logic [2:0] cnt;
		logic [7:0] shreg;
		logic [7:0] op;
		logic [1:0] sck_sync;
		logic [1:0] cs_sync;
		logic [3:0] io0_sync;
		logic [7:0] io_sync;
		logic       sck_prev;
		logic [7:0] stat_nv;
		logic [7:0] stat_v;
		logic       loaded;
		cmd_pulse_s pulse;
		logic       refused;
	} core_s;
endpackage : flash_cmd_pkg

// *** hw/flash_cmd_status.sv ***
// Command decoder and non-volatile status byte of a serial flash
`timescale 1ns/1ps
module flash_cmd_status
	import flash_cmd_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       clk_en_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic [3:0] io_i,
	input  wire logic       wp_n_i,
	input  wire logic       four_wire_instruction_mode_i,
	input  wire logic       cfg_vol_protect_i,
	output logic [7:0]      status_one_nonvolatile_o,
	output logic [7:0]      status_one_volatile_o,
	output logic            enter_wide_addr_cmd_o,
	output logic            enter_sleep_cmd_o,
	output logic            suspend_cmd_o,
	output logic            whole_array_erase_cmd_o,
	output logic            legacy_reset_cmd_o,
	output logic            write_refused_o
);
	core_s q, d;
	logic       sck_rise, cs_n, qmode, last_bit;
	logic [7:0] shifted, wr_nv;

	always_comb begin
		sck_rise = q.sck_sync[1] & ~q.sck_prev;
		cs_n     = q.cs_sync[1];
		qmode    = four_wire_instruction_mode_i;
		shifted  = qmode ? {q.shreg[3:0], q.io_sync[7:4]} : {q.shreg[6:0], q.io0_sync[1]};
		last_bit = qmode ? (q.cnt == NIB_CNT_LAST) : (q.cnt == BIT_CNT_LAST);
		wr_nv    = q.stat_nv;
		d        = q;
		d.sck_sync = {q.sck_sync[0], sck_i};
		d.cs_sync  = {q.cs_sync[0], cs_n_i};
		d.io0_sync = {q.io0_sync[2:0], q.io0_sync[1]};
		d.io0_sync[0] = io_i[0];
		// Nibble lines get two stages like every other pin
		d.io_sync  = {q.io_sync[3:0], io_i};
		d.sck_prev = q.sck_sync[1];
		d.pulse    = '0;
		d.refused  = 1'b0;
		if (!q.loaded) begin
			d.stat_v = q.stat_nv;
			d.loaded = 1'b1;
		end
		if (cfg_vol_protect_i) begin
			d.stat_nv[BIT_RANGE_LO +: 3] = RANGE_FROZEN;
		end else begin
			d.stat_v[BIT_RANGE_LO +: 3] = q.stat_nv[BIT_RANGE_LO +: 3];
		end
		d.stat_v[BIT_LOCK] = q.stat_nv[BIT_LOCK];
		if (cs_n) begin
			d.phase = ST_OPCODE;
			d.cnt   = '0;
		end else if (sck_rise && q.phase != ST_IGNORE) begin
			d.shreg = shifted;
			d.cnt   = q.cnt + 3'h1;
			if (last_bit) begin
				d.cnt   = '0;
				d.phase = ST_IGNORE;
				if (q.phase == ST_OPCODE) begin
					d.op = shifted;
					case (shifted)
						OP_WIDE_ADDR: d.pulse.wide_addr = ~qmode;
						OP_SLEEP: d.pulse.sleep = 1'b1;
						OP_SUSPEND_ALT: d.pulse.suspend = 1'b1;
						OP_ERASE_ALT: begin
							d.pulse.erase = q.stat_v[BIT_WEL];
						end
						OP_LEGACY_RST: d.pulse.soft_reset = ~qmode;
						OP_WREN: d.stat_v[BIT_WEL] = 1'b1;
						OP_WRDI: d.stat_v[BIT_WEL] = 1'b0;
						OP_WRITE_STAT: d.phase = ST_DATA;
						default: d.phase = ST_IGNORE;
					endcase
				end else begin
					if (!q.stat_v[BIT_WEL]) begin
						d.refused = 1'b1;
					end else if (q.stat_nv[BIT_LOCK] && !q.io0_sync[3]) begin
						d.refused = 1'b1;
					end else begin
						// Read-only default bits keep their stored value
						wr_nv = (shifted & ~STAT_RO_MASK) | (q.stat_nv & STAT_RO_MASK);
						if (cfg_vol_protect_i) begin
							wr_nv[BIT_RANGE_LO +: 3] = RANGE_FROZEN;
							d.stat_v[BIT_RANGE_LO +: 3] = shifted[BIT_RANGE_LO +: 3];
						end
						// Latch is left alone: only enable and disable move it
						d.stat_nv = wr_nv;
					end
				end
			end
		end
		// Pin is sampled through the spare sync stages of the io0 chain
		d.io0_sync[3] = q.io0_sync[2];
		d.io0_sync[2] = wp_n_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			q <= '{phase: ST_OPCODE, cnt: '0, shreg: '0, op: '0, sck_sync: '0,
				cs_sync: 2'b11, io0_sync: '0, io_sync: '0, sck_prev: 1'b0,
				stat_nv: STAT_NV_RESET, stat_v: '0, loaded: 1'b0, pulse: '0,
				refused: 1'b0};
		end else if (clk_en_i) begin
			q <= d;
		end
	end

	always_comb begin
		status_one_nonvolatile_o = q.stat_nv;
		status_one_volatile_o    = q.stat_v;
		enter_wide_addr_cmd_o    = q.pulse.wide_addr;
		enter_sleep_cmd_o        = q.pulse.sleep;
		suspend_cmd_o            = q.pulse.suspend;
		whole_array_erase_cmd_o  = q.pulse.erase;
		legacy_reset_cmd_o       = q.pulse.soft_reset;
		write_refused_o          = q.refused;
	end

	AST_WIDE_QPI: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		q.pulse.wide_addr |-> !$past(four_wire_instruction_mode_i))
		else $error("wide address entered in four-wire mode");
	AST_LEGACY_QPI: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		q.pulse.soft_reset |-> !$past(four_wire_instruction_mode_i))
		else $error("legacy reset taken in four-wire mode");
	AST_RANGE_FROZEN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		cfg_vol_protect_i && clk_en_i ##1 clk_en_i
		|=> q.stat_nv[BIT_RANGE_LO +: 3] == RANGE_FROZEN)
		else $error("stored range not frozen");
	AST_RO_BITS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(q.stat_nv & STAT_RO_MASK) == (STAT_NV_RESET & STAT_RO_MASK))
		else $error("read-only status bit changed");
	AST_LOCK_REFUSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		q.refused |-> $stable(q.stat_nv))
		else $error("refused write changed stored status");
	AST_ERASE_WEL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		q.pulse.erase |-> $past(q.stat_v[BIT_WEL]))
		else $error("erase without write enable");
	AST_WEL_ONLY_CMD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$changed(q.stat_v[BIT_WEL]) |-> q.op == OP_WREN || q.op == OP_WRDI)
		else $error("write enable latch moved by another command");
	AST_MIRROR: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!cfg_vol_protect_i && clk_en_i ##1 !cfg_vol_protect_i && clk_en_i
		|=> q.stat_v[BIT_RANGE_LO +: 3] == $past(q.stat_nv[BIT_RANGE_LO +: 3]))
		else $error("volatile range not mirroring");
	AST_ONE_PULSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$onehot0(q.pulse))
		else $error("more than one command pulse");
	AST_LOAD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(q.loaded) |-> q.stat_v == q.stat_nv)
		else $error("power-up load missed");
	COV_SLEEP: cover property (@(posedge ref_clk_i) q.pulse.sleep);
	COV_ERASE: cover property (@(posedge ref_clk_i) q.pulse.erase);
	COV_REFUSE: cover property (@(posedge ref_clk_i) q.refused);
	COV_WIDE: cover property (@(posedge ref_clk_i) q.pulse.wide_addr);
	COV_SUSPEND: cover property (@(posedge ref_clk_i) q.pulse.suspend);
endmodule : flash_cmd_status

// *** testbench/serial_flash_cmd_status_nv_test.sv ***
// Self-checking bench for the command decoder and stored status byte
`timescale 1ns/1ps
module serial_flash_cmd_status_nv_test;
	logic       ref_clk_i = 0, reset_n_i = 0, wp_n_i = 1, quad = 0, cfg = 0, sck, cs_n;
	logic [3:0] io;
	logic [7:0] nv, vol;
	logic [5:0] pl;
	int         cnt[6], exp_c[6], errors = 0, comparisons = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	flash_cmd_status i_dut(.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
		.sck_i(sck), .cs_n_i(cs_n), .io_i(io), .wp_n_i(wp_n_i),
		.four_wire_instruction_mode_i(quad), .cfg_vol_protect_i(cfg),
		.status_one_nonvolatile_o(nv), .status_one_volatile_o(vol),
		.enter_wide_addr_cmd_o(pl[0]), .enter_sleep_cmd_o(pl[1]), .suspend_cmd_o(pl[2]),
		.whole_array_erase_cmd_o(pl[3]), .legacy_reset_cmd_o(pl[4]), .write_refused_o(pl[5]));
	spi_host_model i_host(.clk_i(ref_clk_i), .quad_i(quad), .sck_o(sck), .cs_n_o(cs_n), .io_o(io));
	// Pulses are counted so a missing or doubled pulse shows after each frame
	always @(negedge ref_clk_i) for (int i = 0; i < 6; i++) if (pl[i] === 1'b1) cnt[i]++;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cmd(input logic [7:0] op, input logic [7:0] dat, input bit wd, input int hit);
		i_host.frame(op, dat, wd);
		repeat (8) @(posedge ref_clk_i);
		if (hit >= 0) exp_c[hit]++;
		for (int i = 0; i < 6; i++) chk(cnt[i], exp_c[i]);
	endtask : cmd
	task report_and_stop();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1 reset_n_i = 1;
		repeat (5) @(posedge ref_clk_i);
		chk(nv, 8'h00);
		chk(vol, 8'h00);
		cmd(8'hb7, 8'h00, 0, 0);
		cmd(8'hb9, 8'h00, 0, 1);
		cmd(8'hb0, 8'h00, 0, 2);
		cmd(8'hc7, 8'h00, 0, -1);
		cmd(8'h06, 8'h00, 0, -1);
		chk(vol, 8'h02);
		cmd(8'hc7, 8'h00, 0, 3);
		cmd(8'hf0, 8'h00, 0, 4);
		cmd(8'haf, 8'h00, 0, -1);
		#1 quad = 1;
		cmd(8'hb7, 8'h00, 0, -1);
		cmd(8'hb9, 8'h00, 0, 1);
		cmd(8'hb0, 8'h00, 0, 2);
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'hc7, 8'h00, 0, 3);
		cmd(8'hf0, 8'h00, 0, -1);
		#1 quad = 0;
		cmd(8'h04, 8'h00, 0, -1);
		cmd(8'h01, 8'hff, 1, 5);
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'h01, 8'hff, 1, -1);
		chk(nv, 8'h9c);
		chk(vol, 8'h9e);
		#1 wp_n_i = 0;
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'h01, 8'h00, 1, 5);
		chk(nv, 8'h9c);
		#1 wp_n_i = 1;
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'h01, 8'h00, 1, -1);
		chk(nv, 8'h00);
		#1 wp_n_i = 0;
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'h01, 8'h10, 1, -1);
		chk(nv, 8'h10);
		#1 cfg = 1;
		repeat (4) @(posedge ref_clk_i);
		chk(nv, 8'h1c);
		cmd(8'h06, 8'h00, 0, -1);
		cmd(8'h01, 8'h04, 1, -1);
		chk(nv, 8'h1c);
		chk(vol, 8'h06);
		report_and_stop();
	end
endmodule : serial_flash_cmd_status_nv_test

// *** testbench/spi_host_model.sv ***
// Behavioural host controller that clocks instruction frames into the flash
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic       clk_i,
	input  wire logic       quad_i,
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h5;
	end
	// Half period of four reference clocks gives the 200 ns link clock
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask : half
	// One frame: opcode, then a data byte when wd is set; MSB first
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit wd);
		logic [15:0] sh;
		int          n;
		sh = {op, dat};
		n = wd ? 16 : 8;
		half();
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i += (quad_i ? 4 : 1)) begin
			if (quad_i)
				io_o = sh[15 - i -: 4];
			else
				io_o[0] = sh[15 - i];
			half();
			sck_o = 1'b1;
			half();
			sck_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		// Released lines must not keep the last value, so drive its inverse
		io_o = ~io_o;
		half();
	endtask : frame
endmodule : spi_host_model
